// >>> logic/lsf_flags.sv
// Purpose: Latching limit status flags, summary bit and alert.
// Assumes: Register strobes and measurement inputs are synchronous.
// Notes:   Register reads return data one cycle after the strobe.
`include "lsf_cfg.svh"

module lsf_flags #(
    parameter int unsigned TICK_CYCLES = `LSF_TIMER_TICK_CYC
) (
    // Clock and reset
    input wire logic clock_i,
    input wire logic srst_i,
    // Register port
    input wire lsf_pkg::lsf_reg_req_t req_i,
    output logic [7:0] reg_rdata_o,
    // Measurements and programmed limits
    input wire lsf_pkg::lsf_meas_t meas_i,
    input wire lsf_pkg::lsf_limits_t limits_i,
    input wire logic [2:0][7:0] thermal_shutdown_pin_limit_i,
    input wire logic [7:0] temp_hysteresis_i,
    input wire logic [7:0] timer_limit_i,
    // Fans and diodes
    input wire logic [3:0] fan_slow_i,
    input wire logic [2:0] pwm_off_i,
    input wire logic [1:0] diode_fault_i,
    // Pin configuration and inputs
    input wire logic code_select_i,
    input wire logic [5:0] voltage_code_i,
    input wire lsf_pkg::lsf_pin_mode_t pin_mode_i,
    input wire logic thermal_shutdown_pin_n_i,
    input wire logic shared_general_pin_i,
    input wire logic [7:0] mask2_i,
    // Outputs
    output logic shared_general_pin_o,
    output logic shared_general_pin_oe_o,
    output logic monitor_enable_o,
    output logic pwm_full_o,
    output logic alert_o
);
    // ------------------------------------------------------------
    // Register strobes
    // ------------------------------------------------------------
    wire logic wr_cfg;
    wire logic wr_st2;
    wire logic rd_st1;
    wire logic rd_st2;
    assign wr_cfg = req_i.wr && (req_i.addr == `LSF_OFS_CONFIG1);
    assign wr_st2 = req_i.wr && (req_i.addr == `LSF_OFS_STATUS2);
    assign rd_st1 = req_i.rd && (req_i.addr == `LSF_OFS_STATUS1);
    assign rd_st2 = req_i.rd && (req_i.addr == `LSF_OFS_STATUS2);

    // ------------------------------------------------------------
    // Configuration register
    // ------------------------------------------------------------
    logic [7:0] config1;
    logic [7:0] next_config1;
    wire logic monitor_start_bit;
    wire logic cfg_locked;
    wire logic [7:0] cfg_wmask;
    assign monitor_start_bit = config1[`LSF_CFG_START_BIT];
    assign cfg_locked = config1[`LSF_CFG_LOCK_BIT];
    // Locked bits drop out of the write mask; start never does.
    assign cfg_wmask = cfg_locked ?
        (`LSF_CFG_WRITE_MASK & ~`LSF_CFG_LOCKABLE_MASK) :
        `LSF_CFG_WRITE_MASK;
    assign next_config1 = (config1 & ~cfg_wmask)
        | (req_i.wdata & cfg_wmask);

    // Only reset releases the lock, so it models a power cycle.
    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            config1 <= `LSF_CONFIG1_RESET;
        end else if (wr_cfg) begin
            config1 <= next_config1;
        end
    end

    assign monitor_enable_o = monitor_start_bit;
    assign pwm_full_o = !monitor_start_bit;

    // ------------------------------------------------------------
    // Limit selection and window comparators
    // ------------------------------------------------------------
    // Programmed limits stay untouched while defaults are in use.
    logic [5:0] out_of_limit;
    genvar ch;
    generate
        for (ch = 0; ch < 6; ch++) begin : g_cmp
            localparam bit IS_TEMP = (ch >= 2) && (ch <= 4);
            wire logic [7:0] lo_sel;
            wire logic [7:0] hi_sel;
            assign lo_sel = monitor_start_bit ? limits_i.low[ch] :
                (IS_TEMP ? `LSF_TEMP_LOW_DEFAULT :
                 `LSF_VOLT_LOW_DEFAULT);
            assign hi_sel = monitor_start_bit ? limits_i.high[ch] :
                (IS_TEMP ? `LSF_TEMP_HIGH_DEFAULT :
                 `LSF_VOLT_HIGH_DEFAULT);
            lsf_limit_cmp u_cmp (
                .reading_i(meas_i.value[ch]),
                .low_i(lo_sel),
                .high_i(hi_sel),
                .signed_i(IS_TEMP),
                .out_of_limit_o(out_of_limit[ch])
            );
        end
    endgenerate

    // ------------------------------------------------------------
    // Voltage code change detector
    // ------------------------------------------------------------
    logic [10:0] code_cnt;
    logic [5:0] code_snap;
    wire logic code_tick;
    wire logic code_changed;
    assign code_tick =
        (code_cnt == 11'(`LSF_CODE_WINDOW_CYC - 1));
    assign code_changed = (voltage_code_i != code_snap);

    // A snapshot every 11 us is the reference for the next window.
    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            code_cnt <= 11'h000;
            code_snap <= 6'h00;
        end else begin
            code_cnt <= code_tick ? 11'h000 : code_cnt + 11'h001;
            if (code_tick) begin
                code_snap <= voltage_code_i;
            end
        end
    end

    // ------------------------------------------------------------
    // Thermal timer accumulator
    // ------------------------------------------------------------
    logic [31:0] tick_cnt;
    logic [15:0] thermal_shutdown_pin_time;
    wire logic timer_mode;
    wire logic tick;
    assign timer_mode = (pin_mode_i == lsf_pkg::LSF_PIN_TIMER);
    assign tick = (tick_cnt == 32'(TICK_CYCLES - 1));

    // Counts time units while the input is asserted (low); the sum
    // saturates and restarts on each read of the second register.
    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            tick_cnt <= 32'h0000_0000;
            thermal_shutdown_pin_time <= 16'h0000;
        end else begin
            if (!timer_mode || thermal_shutdown_pin_n_i || tick) begin
                tick_cnt <= 32'h0000_0000;
            end else begin
                tick_cnt <= tick_cnt + 32'h0000_0001;
            end
            if (rd_st2 || !timer_mode) begin
                thermal_shutdown_pin_time <= 16'h0000;
            end else if (tick && !thermal_shutdown_pin_n_i &&
                         thermal_shutdown_pin_time != 16'hffff) begin
                thermal_shutdown_pin_time <= thermal_shutdown_pin_time + 16'h0001;
            end
        end
    end

    // ------------------------------------------------------------
    // Overtemperature set and hold conditions
    // ------------------------------------------------------------
    logic [2:0] ovt_over;
    logic [2:0] ovt_above_hyst;
    generate
        for (ch = 0; ch < 3; ch++) begin : g_ovt
            wire logic signed [9:0] t_val;
            wire logic signed [9:0] t_lim;
            wire logic signed [9:0] t_rel;
            assign t_val = 10'(signed'(meas_i.value[ch + 2]));
            assign t_lim = 10'(signed'(thermal_shutdown_pin_limit_i[ch]));
            assign t_rel = t_lim - signed'({2'b00, temp_hysteresis_i});
            assign ovt_over[ch] = t_val > t_lim;
            assign ovt_above_hyst[ch] = t_val >= t_rel;
        end
    endgenerate

    // ------------------------------------------------------------
    // Event conditions
    // ------------------------------------------------------------
    logic [7:0] cond1;
    logic [7:0] cond2;
    logic [7:0] hold2;
    logic [2:0] fan_cond;
    wire logic shared_cond;
    wire logic shared_is_flag;
    generate
        for (ch = 0; ch < 3; ch++) begin : g_fan
            assign fan_cond[ch] = fan_slow_i[ch] && !pwm_off_i[ch];
        end
    endgenerate

    assign shared_is_flag = (pin_mode_i == lsf_pkg::LSF_PIN_TACH) ||
        timer_mode;
    assign shared_cond =
        (pin_mode_i == lsf_pkg::LSF_PIN_TACH) ?
            (fan_slow_i[3] && !pwm_off_i[2]) :
            (timer_mode && (thermal_shutdown_pin_time > {8'h00, timer_limit_i}));

    // Bits 0 and 1 of the first register belong elsewhere.
    assign cond1 = {1'b0, out_of_limit[4:0], 2'b00};
    assign cond2 = {
        diode_fault_i[1],
        diode_fault_i[0],
        shared_cond,
        fan_cond,
        |ovt_over,
        code_select_i ? code_changed : out_of_limit[5]
    };
    // Overtemperature clears only after falling below hysteresis.
    assign hold2 = {cond2[7:2], |ovt_above_hyst, cond2[0]};

    // ------------------------------------------------------------
    // Latched flags
    // ------------------------------------------------------------
    logic [7:0] status1;
    logic [7:0] status2;
    logic [7:0] next_status1;
    logic [7:0] next_status2;
    logic [7:0] st2_keep;
    // A live cause wins over the clearing read in every cycle.
    assign next_status1 = cond1 | (status1 & ~({8{rd_st1}}
        & ~cond1));
    assign st2_keep = status2 & ~({8{rd_st2}} & ~hold2);
    assign next_status2 = (cond2 | st2_keep)
        & {2'b11, shared_is_flag, 5'h1f};

    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            status1 <= `LSF_STATUS_RESET;
            status2 <= `LSF_STATUS_RESET;
        end else begin
            status1 <= next_status1;
            status2 <= next_status2;
        end
    end

    // ------------------------------------------------------------
    // Shared general pin
    // ------------------------------------------------------------
    logic gp_out;
    wire logic gp_out_mode;
    wire logic gp_in_mode;
    assign gp_out_mode = (pin_mode_i == lsf_pkg::LSF_PIN_GP_OUT);
    assign gp_in_mode = (pin_mode_i == lsf_pkg::LSF_PIN_GP_IN);

    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            gp_out <= 1'b0;
        end else if (wr_st2 && gp_out_mode) begin
            gp_out <= req_i.wdata[`LSF_ST2_SHARED_BIT];
        end
    end

    assign shared_general_pin_o = gp_out;
    assign shared_general_pin_oe_o = gp_out_mode;

    // ------------------------------------------------------------
    // Summary and alert
    // ------------------------------------------------------------
    wire logic second_status_summary;
    wire logic [7:0] st1_view;
    wire logic [7:0] st2_view;
    wire logic shared_view;
    assign second_status_summary = |status2;
    assign st1_view = {second_status_summary, status1[6:0]};
    assign shared_view = gp_out_mode ? gp_out :
        (gp_in_mode ? shared_general_pin_i : status2[5]);
    assign st2_view = {status2[7:6], shared_view, status2[4:0]};

    // The summary bit itself never alerts; masking stops second
    // register events at the alert while they still show there.
    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            alert_o <= 1'b0;
        end else begin
            alert_o <= (|status1[6:0]) | (|(status2 & ~mask2_i));
        end
    end

    // ------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------
    wire logic [7:0] rd_mux;
    assign rd_mux =
        (req_i.addr == `LSF_OFS_CONFIG1) ? config1 :
        (req_i.addr == `LSF_OFS_STATUS1) ? st1_view :
        (req_i.addr == `LSF_OFS_STATUS2) ? st2_view : 8'h00;

    // Data shows the value before the clearing edge of the read.
    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            reg_rdata_o <= 8'h00;
        end else if (req_i.rd) begin
            reg_rdata_o <= rd_mux;
        end
    end
endmodule // lsf_flags

// >>> inc/lsf_cfg.svh
// Purpose: Offsets, field positions, reset values and timing counts.
// Assumes: 100 MHz system clock.
// Notes:   Definitions only; included by bare name.
`ifndef LSF_CFG_SVH
`define LSF_CFG_SVH

// ------------------------------------------------------------
// Register offsets
// ------------------------------------------------------------
`define LSF_OFS_CONFIG1 8'h40
`define LSF_OFS_STATUS1 8'h41
`define LSF_OFS_STATUS2 8'h42

// ------------------------------------------------------------
// Field positions
// ------------------------------------------------------------
`define LSF_CFG_START_BIT 0
`define LSF_CFG_LOCK_BIT 1
`define LSF_CFG_READY_BIT 2
`define LSF_CFG_LOCKABLE_MASK 8'h52
`define LSF_CFG_WRITE_MASK 8'h7b
`define LSF_ST2_SHARED_BIT 5

// ------------------------------------------------------------
// Reset values
// ------------------------------------------------------------
`define LSF_CONFIG1_RESET 8'h04
`define LSF_STATUS_RESET 8'h00
`define LSF_VOLT_LOW_DEFAULT 8'h00
`define LSF_VOLT_HIGH_DEFAULT 8'hff
`define LSF_TEMP_LOW_DEFAULT 8'h81
`define LSF_TEMP_HIGH_DEFAULT 8'h7f

// ------------------------------------------------------------
// Timing
// ------------------------------------------------------------
`define LSF_CLK_MHZ 100
`define LSF_CODE_WINDOW_US 11
`define LSF_CODE_WINDOW_CYC (`LSF_CODE_WINDOW_US * `LSF_CLK_MHZ)
`define LSF_TIMER_TICK_US 1000
`define LSF_TIMER_TICK_CYC (`LSF_TIMER_TICK_US * `LSF_CLK_MHZ)

`endif

// >>> inc/lsf_pkg.sv
// Purpose: Types shared by the status flag block and its bench.
// Assumes: Constants live in lsf_cfg.svh.
// Notes:   Nothing here is imported; use lsf_pkg::name.
package lsf_pkg;

    // --------------------------------------------------------
    // Shared pin function
    // --------------------------------------------------------
    typedef enum logic [1:0] {
        LSF_PIN_TACH,
        LSF_PIN_TIMER,
        LSF_PIN_GP_OUT,
        LSF_PIN_GP_IN
    } lsf_pin_mode_t;

    // Channel order: 0 core, 1 five volt, 2 remote one, 3 local,
    // 4 remote two, 5 twelve volt.
    typedef struct packed {
        logic [5:0][7:0] value;
    } lsf_meas_t;

    typedef struct packed {
        logic [5:0][7:0] low;
        logic [5:0][7:0] high;
    } lsf_limits_t;

    // Register access strobe with its address and data.
    typedef struct packed {
        logic [7:0] addr;
        logic wr;
        logic rd;
        logic [7:0] wdata;
    } lsf_reg_req_t;

endpackage

// >>> logic/lsf_limit_cmp.sv
// Purpose: One window comparison of a reading against its limits.
// Assumes: Readings and limits share one encoding.
// Notes:   Signed mode suits twos-complement temperatures.
module lsf_limit_cmp (
    // Reading and limits
    input wire logic [7:0] reading_i,
    input wire logic [7:0] low_i,
    input wire logic [7:0] high_i,
    input wire logic signed_i,
    // Result
    output logic out_of_limit_o
);
    // ------------------------------------------------------------
    // Comparison
    // ------------------------------------------------------------
    // Flipping the sign bit turns a signed compare into unsigned.
    wire logic [7:0] r_adj;
    wire logic [7:0] lo_adj;
    wire logic [7:0] hi_adj;
    assign r_adj = {reading_i[7] ^ signed_i, reading_i[6:0]};
    assign lo_adj = {low_i[7] ^ signed_i, low_i[6:0]};
    assign hi_adj = {high_i[7] ^ signed_i, high_i[6:0]};
    // High is strictly above, low is at or below.
    assign out_of_limit_o = (r_adj > hi_adj) || (r_adj <= lo_adj);
endmodule // lsf_limit_cmp

// >>> tb/lsf_flags_monitor.sv
// Purpose: Concurrent checks on the status flag block's ports.
// Assumes: One clock domain, synchronous active-high reset.
// Notes:   Bound onto every lsf_flags instance.
`include "lsf_cfg.svh"

module lsf_flags_monitor (
    // Clock and reset
    input wire logic clock_i,
    input wire logic srst_i,
    // Register port
    input wire lsf_pkg::lsf_reg_req_t req_i,
    input wire logic [7:0] reg_rdata_o,
    // Causes and masks
    input wire logic [3:0] fan_slow_i,
    input wire logic [2:0] pwm_off_i,
    input wire logic [1:0] diode_fault_i,
    input wire logic [7:0] mask2_i,
    input wire lsf_pkg::lsf_pin_mode_t pin_mode_i,
    // Outputs
    input wire logic shared_general_pin_oe_o,
    input wire logic monitor_enable_o,
    input wire logic pwm_full_o,
    input wire logic alert_o
);
    timeunit 1ns;
    timeprecision 1ps;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (srst_i);

    // Outputs must come out of reset quiet and unmonitored.
    a_reset_quiet: assert property ($fell(srst_i) |-> !alert_o &&
        !monitor_enable_o && reg_rdata_o == 8'h00)
        else $error("outputs not at reset values");
    a_pwm_thermal: assert property (pwm_full_o == !monitor_enable_o)
        else $error("pwm full does not follow start bit");
    a_start_write: assert property (req_i.wr &&
        req_i.addr == `LSF_OFS_CONFIG1 |=>
        monitor_enable_o == $past(req_i.wdata[0]))
        else $error("start bit write lost");
    a_gp_enable: assert property (shared_general_pin_oe_o ==
        (pin_mode_i == lsf_pkg::LSF_PIN_GP_OUT))
        else $error("pin enable wrong for mode");
    // An unmasked fan fault must reach the alert two edges later.
    a_fan_alert: assert property (fan_slow_i[0] && !pwm_off_i[0] &&
        !mask2_i[2] ##1 !mask2_i[2] |=> alert_o)
        else $error("fan fault raised no alert");
    a_diode_alert: assert property (diode_fault_i[1] &&
        !mask2_i[7] ##1 !mask2_i[7] |=> alert_o)
        else $error("diode fault raised no alert");
    a_data_holds: assert property (!req_i.rd |=> $stable(reg_rdata_o))
        else $error("read data moved without a read");
    a_unmapped_zero: assert property (req_i.rd && (req_i.addr < 8'h40
        || req_i.addr > 8'h42) |=> reg_rdata_o == 8'h00)
        else $error("unmapped read not zero");
    a_low_bits_zero: assert property (req_i.rd &&
        req_i.addr == `LSF_OFS_STATUS1 |=> reg_rdata_o[1:0] == 2'b00)
        else $error("unused status bits set");
endmodule // lsf_flags_monitor

bind lsf_flags lsf_flags_monitor mon_u (.clock_i(clock_i),
    .srst_i(srst_i), .req_i(req_i), .reg_rdata_o(reg_rdata_o),
    .fan_slow_i(fan_slow_i), .pwm_off_i(pwm_off_i),
    .diode_fault_i(diode_fault_i), .mask2_i(mask2_i),
    .pin_mode_i(pin_mode_i),
    .shared_general_pin_oe_o(shared_general_pin_oe_o),
    .monitor_enable_o(monitor_enable_o), .pwm_full_o(pwm_full_o),
    .alert_o(alert_o));

// >>> tb/lsf_host.sv
// Purpose: Host side of the register port, issuing single accesses.
// Assumes: Strobes are one-cycle pulses; data valid one edge later.
// Notes:   Requests leave on one edge and drop on the taking edge.
module lsf_host (
    // Clock
    input wire logic clock_i,
    // Register port
    output lsf_pkg::lsf_reg_req_t req_o,
    input wire logic [7:0] rdata_i
);
    timeunit 1ns;
    timeprecision 1ps;

    initial req_o = '0;

    // One write; the request is held exactly one cycle.
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge clock_i) req_o <= '{a, 1'b1, 1'b0, v};
        @(posedge clock_i) req_o <= '0;
        #1;
    endtask

    // One read; data is taken after the taking edge has settled.
    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        @(posedge clock_i) req_o <= '{a, 1'b0, 1'b1, 8'h00};
        @(posedge clock_i) req_o <= '0;
        #1 v = rdata_i;
    endtask
endmodule // lsf_host

// >>> tb/test_limit_status_flags.sv
// Purpose: Self-checking bench for the latching status flag block.
// Assumes: Timer tick shortened to 4 cycles.
// Notes:   Limit readings are random within the legal window.
`include "lsf_cfg.svh"

module test_limit_status_flags;
    timeunit 1ns;
    timeprecision 1ps;

    logic clock_i = 1'b0;
    logic srst_i = 1'b1;
    lsf_pkg::lsf_reg_req_t req;
    lsf_pkg::lsf_meas_t meas;
    lsf_pkg::lsf_limits_t lim;
    lsf_pkg::lsf_pin_mode_t mode;
    logic [2:0][7:0] tlim;
    logic [7:0] rdata, d, hyst, tmr, mask2;
    logic [3:0] fan;
    logic [2:0] pwm_off;
    logic [1:0] diode;
    logic [5:0] code;
    logic csel, pin_n, gp_i, gp_o, gp_oe, mon, pwm_full, alert;
    int failures = 0;
    int checks = 0;
    int cycles = 0;

    always #5 clock_i = ~clock_i;

    lsf_host host_u (.clock_i(clock_i), .req_o(req), .rdata_i(rdata));
    lsf_flags #(.TICK_CYCLES(4)) dut_u (.clock_i(clock_i),
        .srst_i(srst_i), .req_i(req), .reg_rdata_o(rdata),
        .meas_i(meas), .limits_i(lim), .thermal_shutdown_pin_limit_i(tlim),
        .temp_hysteresis_i(hyst), .timer_limit_i(tmr),
        .fan_slow_i(fan), .pwm_off_i(pwm_off), .diode_fault_i(diode),
        .code_select_i(csel), .voltage_code_i(code), .pin_mode_i(mode),
        .thermal_shutdown_pin_n_i(pin_n), .shared_general_pin_i(gp_i),
        .mask2_i(mask2), .shared_general_pin_o(gp_o),
        .shared_general_pin_oe_o(gp_oe), .monitor_enable_o(mon),
        .pwm_full_o(pwm_full), .alert_o(alert));

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    task automatic check(string name, logic [7:0] seen, logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            failures++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic rdchk(string name, logic [7:0] a, logic [7:0] exp);
        host_u.rd(a, d);
        check(name, d, exp);
    endtask

    // Temperatures are signed, so their window straddles zero.
    function automatic logic [7:0] mid_val(int ch);
        if (ch < 2 || ch == 5) return 8'(8'h11 + $urandom % 224);
        return 8'(8'hf1 + $urandom % 80);
    endfunction

    function automatic logic [7:0] st1(int ch);
        return 8'h01 << (ch + 2);
    endfunction

    task automatic test_done();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask

    // Longest path is one 1200-cycle code wait plus some sixty accesses.
    always @(posedge clock_i) begin
        cycles++;
        if (cycles == 20000) begin
            failures++;
            test_done();
        end
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        void'($urandom(32'hb00099ac));
        for (int ch = 0; ch < 6; ch++) begin
            lim.low[ch] = (ch < 2 || ch == 5) ? 8'h10 : 8'hf0;
            lim.high[ch] = (ch < 2 || ch == 5) ? 8'hf0 : 8'h40;
            meas.value[ch] = mid_val(ch);
        end
        tlim = {3{8'h7f}};
        {hyst, tmr, mask2, fan, pwm_off, diode} = {8'h05, 8'h02, 17'h0};
        {csel, pin_n, gp_i, code} = {3'b010, 6'h00};
        mode = lsf_pkg::LSF_PIN_TACH;
        repeat (3) @(posedge clock_i);
        srst_i <= 1'b0;
        rdchk("status2", `LSF_OFS_STATUS2, 8'h00);
        rdchk("config1", `LSF_OFS_CONFIG1, 8'h04);
        host_u.wr(`LSF_OFS_CONFIG1, 8'h01);
        check("monitor", {7'h0, mon}, 8'h01);
        check("pwm_full", {7'h0, pwm_full}, 8'h00);
        for (int ch = 0; ch < 5; ch++) begin
            @(posedge clock_i) meas.value[ch] <= lim.high[ch];
            rdchk("at_high", `LSF_OFS_STATUS1, 8'h00);
            @(posedge clock_i) meas.value[ch] <= lim.low[ch];
            rdchk("at_low", `LSF_OFS_STATUS1, st1(ch));
            check("alert", {7'h0, alert}, 8'h01);
            rdchk("persist", `LSF_OFS_STATUS1, st1(ch));
            @(posedge clock_i) meas.value[ch] <= lim.high[ch] + 8'h01;
            rdchk("above", `LSF_OFS_STATUS1, st1(ch));
            @(posedge clock_i) meas.value[ch] <= mid_val(ch);
            rdchk("latched", `LSF_OFS_STATUS1, st1(ch));
            rdchk("cleared", `LSF_OFS_STATUS1, 8'h00);
        end
        @(posedge clock_i) mask2 <= 8'hff;
        {fan, pwm_off, diode} <= {4'hf, 3'h4, 2'h3};
        repeat (3) @(posedge clock_i);
        #1 check("masked", {7'h0, alert}, 8'h00);
        rdchk("summary", `LSF_OFS_STATUS1, 8'h80);
        rdchk("fans", `LSF_OFS_STATUS2, 8'hcc);
        @(posedge clock_i) mask2 <= 8'h00;
        repeat (3) @(posedge clock_i);
        #1 check("unmasked", {7'h0, alert}, 8'h01);
        @(posedge clock_i) {fan, pwm_off, diode} <= 9'h0;
        rdchk("fans_held", `LSF_OFS_STATUS2, 8'hcc);
        rdchk("fans_clr", `LSF_OFS_STATUS2, 8'h00);
        rdchk("summary_clr", `LSF_OFS_STATUS1, 8'h00);
        @(posedge clock_i) {tlim[1], meas.value[3]} <= 16'h3031;
        rdchk("ovt", `LSF_OFS_STATUS2, 8'h02);
        @(posedge clock_i) meas.value[3] <= 8'h2e;
        rdchk("ovt_hyst", `LSF_OFS_STATUS2, 8'h02);
        rdchk("ovt_hyst", `LSF_OFS_STATUS2, 8'h02);
        @(posedge clock_i) meas.value[3] <= 8'h20;
        rdchk("ovt_last", `LSF_OFS_STATUS2, 8'h02);
        rdchk("ovt_clr", `LSF_OFS_STATUS2, 8'h00);
        @(posedge clock_i) meas.value[5] <= 8'hf1;
        rdchk("twelve", `LSF_OFS_STATUS2, 8'h01);
        @(posedge clock_i) {csel, meas.value[5]} <= 9'h180;
        repeat (1200) @(posedge clock_i);
        repeat (2) host_u.rd(`LSF_OFS_STATUS2, d);
        @(posedge clock_i) code <= 6'h2a;
        rdchk("code_chg", `LSF_OFS_STATUS2, 8'h01);
        @(posedge clock_i) csel <= 1'b0;
        repeat (2) host_u.rd(`LSF_OFS_STATUS2, d);
        @(posedge clock_i) mode <= lsf_pkg::LSF_PIN_TIMER;
        pin_n <= 1'b0;
        repeat (20) @(posedge clock_i);
        rdchk("timer", `LSF_OFS_STATUS2, 8'h20);
        @(posedge clock_i) mode <= lsf_pkg::LSF_PIN_GP_OUT;
        pin_n <= 1'b1;
        host_u.wr(`LSF_OFS_STATUS2, 8'h20);
        check("gp_out", {6'h0, gp_oe, gp_o}, 8'h03);
        @(posedge clock_i) mode <= lsf_pkg::LSF_PIN_GP_IN;
        gp_i <= 1'b1;
        rdchk("gp_in", `LSF_OFS_STATUS2, 8'h20);
        host_u.wr(`LSF_OFS_CONFIG1, 8'h13);
        host_u.wr(`LSF_OFS_CONFIG1, 8'h00);
        rdchk("locked", `LSF_OFS_CONFIG1, 8'h16);
        check("protect", {7'h0, pwm_full}, 8'h01);
        host_u.wr(`LSF_OFS_CONFIG1, 8'h01);
        check("restart", {7'h0, mon}, 8'h01);
        host_u.wr(`LSF_OFS_STATUS1, 8'hff);
        rdchk("ro_status", `LSF_OFS_STATUS1, 8'h00);
        rdchk("unmapped", 8'h55, 8'h00);
        // The cause is present only at the edge that takes the read.
        fork
            host_u.rd(`LSF_OFS_STATUS1, d);
            begin
                @(posedge clock_i) meas.value[0] <= lim.low[0];
                @(posedge clock_i) meas.value[0] <= 8'h80;
            end
        join
        check("race_pre", d, 8'h00);
        rdchk("race", `LSF_OFS_STATUS1, st1(0));
        test_done();
    end
endmodule // test_limit_status_flags
